// file: hw/fpmc_pkg.sv
// Shared constants for the flash program memory control block.
// Assumes a 10 MHz system clock and an 8-bit special function register port.
package fpmc_pkg;

  // Register indices on the special function register port
  localparam int          REG_AW          = 4;
  localparam logic [3:0]  IDX_ADDR_LO     = 4'h0;
  localparam logic [3:0]  IDX_ADDR_HI     = 4'h1;
  localparam logic [3:0]  IDX_DATA0_LO    = 4'h2;
  localparam logic [3:0]  IDX_DATA3_HI    = 4'h9;
  localparam logic [3:0]  IDX_MODE_CTRL   = 4'hA;
  localparam logic [3:0]  IDX_BUF_CTRL    = 4'hB;

  // Mode/control register fields
  localparam int          BIT_WPERMIT     = 7;
  localparam int          MODE_LSB        = 4;
  localparam int          MODE_MSB        = 6;
  localparam int          BIT_MCHG        = 3;
  localparam int          BIT_WCYC        = 2;
  localparam int          BIT_RPERMIT     = 1;
  localparam int          BIT_RCYC        = 0;

  // Buffer control register fields
  localparam int          BIT_SOFT_RST    = 4;
  localparam int          BIT_BUF_CLR     = 0;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;

  // Operating mode codes
  localparam logic [2:0]  MODE_WRITE      = 3'h0;
  localparam logic [2:0]  MODE_ERASE      = 3'h1;
  localparam logic [2:0]  MODE_READ       = 3'h3;
  localparam logic [2:0]  MODE_WEN        = 3'h6;

  // Operations issued to the flash array
  localparam logic [1:0]  OP_PROG         = 2'h0;
  localparam logic [1:0]  OP_ERASE        = 2'h1;
  localparam logic [1:0]  OP_READ         = 2'h2;

  // Write enable pattern, first data pair one low byte in the top bits
  localparam logic [47:0] UNLOCK_PAT      = 48'h00040D09C340;

  // Timing
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          UNLOCK_WIN_MS   = 1;
  localparam int          UNLOCK_WIN_CYC  =
    UNLOCK_WIN_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          AUTO_CLR_MS     = 2;
  localparam int          AUTO_CLR_CYC    =
    AUTO_CLR_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_UNLOCK,
    ST_FLASH,
    ST_CLEAR
  } fpmc_state_t;

  // True when a register write hits the given index
  function automatic logic fpmc_wr_hit(input logic       wr,
                                       input logic [3:0] addr,
                                       input logic [3:0] idx);
    fpmc_wr_hit = wr && (addr == idx);
  endfunction

endpackage

// file: hw/fpmc_buf_if.sv
// Write buffer port between the controller and its buffer memory.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fpmc_buf_if #(
  parameter int DW = 16,
  parameter int AW = 6
);
  logic          we;
  logic [AW-1:0] widx;
  logic [DW-1:0] wdata;
  logic [AW-1:0] ridx;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output widx, output wdata, output ridx,
                input rdata);
  modport mem  (input we, input widx, input wdata, input ridx,
                output rdata);
endinterface

// file: hw/fpmc_wbuf.sv
// Page write buffer memory with registered read data.
// Assumes the controller clears it by writing zeros word by word.
`timescale 1ns/1ps
module fpmc_wbuf
  import fpmc_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 6
) (
  input  wire logic clock,
  input  wire logic arst_n,
  fpmc_buf_if.mem   bus
);
  logic [DW-1:0] mem_r [2**AW];
  logic [DW-1:0] rdata_r;

  // Word store
  always_ff @(posedge clock) begin
    if (bus.we) begin
      mem_r[bus.widx] <= bus.wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem_r[bus.ridx];
    end
  end

  assign bus.rdata = rdata_r;
endmodule

// file: hw/fpmc_top.sv
// Flash program memory self-programming control registers and sequencer.
// Assumes a flash array that answers each request with a one-cycle done.
// Summary of operation
// [RQ1] Address low byte fully read/write
// [RQ2] Address high bits from bit 8, sized
// [RQ3] Four data pairs; pair zero carries data
// [RQ4] Clearing enable bit drops write permit
// [RQ5] Writing one to enable bit ignored
// [RQ6] Mode codes: write, erase, read, enable
// [RQ7] Software avoids reserved mode codes
// [RQ8] Mode change bit starts mode cycle
// [RQ9] Mode change bit self-clears when done
// [RQ10] Write bit starts cycle, self-clears
// [RQ11] Reads proceed only with read permit
// [RQ12] Read bit starts cycle, self-clears
// [RQ13] Read start ignored without prior permit
// [RQ14] Software never sets three bits together
// [RQ15] Buffer clear bit clears buffer, self-clears
// [RQ16] Software keeps soft reset bit zero
// [RQ17] Unused buffer control bits read zero
// [RQ18] Control registers reset to zero
// [RQ19] Pattern within 1ms window grants permit
// [RQ20] High byte write buffers word, stops
// [RQ21] Buffer auto-cleared after buffered write
`timescale 1ns/1ps
module fpmc_top
  import fpmc_pkg::*;
#(
  parameter int AHI_W      = 6,
  parameter int PAGE_AW    = 6,
  parameter int UNLOCK_CYC = UNLOCK_WIN_CYC
) (
  input  wire  logic                clock,
  input  wire  logic                arst_n,
  input  wire  logic [REG_AW-1:0]   sfr_addr,
  input  wire  logic                sfr_wr,
  input  wire  logic                sfr_rd,
  input  wire  logic [7:0]          sfr_wdata,
  output logic       [7:0]          sfr_rdata,
  output logic                      fl_req,
  output logic       [1:0]          fl_op,
  output logic       [8+AHI_W-1:0]  fl_addr,
  input  wire  logic                fl_done,
  input  wire  logic [15:0]         fl_rdata,
  input  wire  logic [PAGE_AW-1:0]  fl_buf_idx,
  output logic       [15:0]         fl_buf_data
);
  localparam int AW = 8 + AHI_W;
  localparam int CW = $clog2(UNLOCK_CYC + 1);
  localparam logic [CW-1:0]      CNT_LAST  = CW'(UNLOCK_CYC - 1);
  localparam logic [PAGE_AW-1:0] PAGE_LAST = '1;

  fpmc_state_t        st_r;
  logic [AW-1:0]      addr_r;
  logic [7:0]         d_lo_r [4];
  logic [7:0]         d_hi_r [4];
  logic               permit_r;
  logic [2:0]         mode_r;
  logic               mchg_r;
  logic               wcyc_r;
  logic               rpermit_r;
  logic               rcyc_r;
  logic               soft_rst_r;
  logic               bclr_r;
  logic [CW-1:0]      cnt_r;
  logic [5:0]         seen_r;
  logic [PAGE_AW-1:0] clr_idx_r;
  logic [7:0]         rdata_r;
  logic               req_r;
  logic [1:0]         op_r;
  logic [AW-1:0]      fladdr_r;

  fpmc_buf_if #(.DW(16), .AW(PAGE_AW)) buf_bus ();

  fpmc_wbuf #(.DW(16), .AW(PAGE_AW)) u_wbuf (
    .clock  (clock),
    .arst_n (arst_n),
    .bus    (buf_bus)
  );

  // Register write decode
  wire        wr_alo  = fpmc_wr_hit(sfr_wr, sfr_addr, IDX_ADDR_LO);
  wire        wr_ahi  = fpmc_wr_hit(sfr_wr, sfr_addr, IDX_ADDR_HI);
  wire        wr_fcr  = fpmc_wr_hit(sfr_wr, sfr_addr, IDX_MODE_CTRL);
  wire        wr_flash_buffer_control = fpmc_wr_hit(sfr_wr, sfr_addr, IDX_BUF_CTRL);
  wire        is_data = (sfr_addr >= IDX_DATA0_LO) &&
                        (sfr_addr <= IDX_DATA3_HI);
  wire [3:0]  didx    = sfr_addr - IDX_DATA0_LO;
  wire [1:0]  dsel    = didx[2:1];
  wire        dhi     = didx[0];
  wire        wr_data = sfr_wr && is_data;
  wire        wr_d0hi = fpmc_wr_hit(sfr_wr, sfr_addr, IDX_DATA0_LO + 4'h1);

  // Read view of each register
  wire [7:0]  flash_address_high_v  = 8'(addr_r[AW-1:8]);
  wire [7:0]  fcr_v   = {permit_r, mode_r, mchg_r, wcyc_r, rpermit_r,
                         rcyc_r};
  wire [7:0]  flash_buffer_control_v  = 8'(({7'h00, bclr_r} << BIT_BUF_CLR) |
                           ({7'h00, soft_rst_r} << BIT_SOFT_RST)); // [RQ17]
  wire [7:0]  rd_mux  = (sfr_addr == IDX_ADDR_LO)   ? addr_r[7:0] :
                        (sfr_addr == IDX_ADDR_HI)   ? flash_address_high_v :
                        is_data ? (dhi ? d_hi_r[dsel] : d_lo_r[dsel]) :
                        (sfr_addr == IDX_MODE_CTRL) ? fcr_v :
                        (sfr_addr == IDX_BUF_CTRL)  ? flash_buffer_control_v : 8'h00;

  // Unlock pattern check over data pairs one to three
  wire [47:0] pat_v   = {d_lo_r[1], d_hi_r[1], d_lo_r[2], d_hi_r[2],
                         d_lo_r[3], d_hi_r[3]};
  wire        pat_ok  = (pat_v == UNLOCK_PAT) && (&seen_r);      // [RQ19]

  // Mode decode
  wire        mode_pg = (mode_r == MODE_WRITE) || (mode_r == MODE_ERASE);
  wire        rd_go   = rcyc_r && rpermit_r;                     // [RQ11]
  wire        page_end = (addr_r[PAGE_AW-1:0] == PAGE_LAST);

  // Buffer port selection: clearing walker or software high byte
  assign buf_bus.we    = (st_r == ST_CLEAR) || wr_d0hi;
  assign buf_bus.widx  = (st_r == ST_CLEAR) ? clr_idx_r
                                            : addr_r[PAGE_AW-1:0];
  assign buf_bus.wdata = (st_r == ST_CLEAR) ? 16'h0000
                                            : {sfr_wdata, d_lo_r[0]};
  assign buf_bus.ridx  = fl_buf_idx;

  // Address registers with page-bounded auto increment
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addr_r <= '0;
    end else if (wr_alo) begin
      addr_r[7:0] <= sfr_wdata;                                  // [RQ1]
    end else if (wr_ahi) begin
      addr_r[AW-1:8] <= sfr_wdata[AHI_W-1:0];                    // [RQ2]
    end else if (wr_d0hi && !page_end) begin
      addr_r <= addr_r + AW'(1);                                 // [RQ20]
    end
  end

  // Data pairs; a finished read lands in pair zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        d_lo_r[i] <= 8'h00;
        d_hi_r[i] <= 8'h00;
      end
    end else if (st_r == ST_FLASH && fl_done && op_r == OP_READ) begin
      d_lo_r[0] <= fl_rdata[7:0];                                // [RQ3]
      d_hi_r[0] <= fl_rdata[15:8];
    end else if (wr_data && dhi) begin
      d_hi_r[dsel] <= sfr_wdata;                                 // [RQ3]
    end else if (wr_data) begin
      d_lo_r[dsel] <= sfr_wdata;
    end
  end

  // Read data register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      rdata_r <= rd_mux;
    end
  end

  // Control bits and sequencer; hardware actions follow software writes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r       <= ST_IDLE;                                     // [RQ18]
      permit_r   <= CTRL_RESET[BIT_WPERMIT];
      mode_r     <= CTRL_RESET[MODE_MSB:MODE_LSB];
      mchg_r     <= CTRL_RESET[BIT_MCHG];
      wcyc_r     <= CTRL_RESET[BIT_WCYC];
      rpermit_r  <= CTRL_RESET[BIT_RPERMIT];
      rcyc_r     <= CTRL_RESET[BIT_RCYC];
      soft_rst_r <= CTRL_RESET[BIT_SOFT_RST];
      bclr_r     <= CTRL_RESET[BIT_BUF_CLR];
      cnt_r      <= '0;
      seen_r     <= '0;
      clr_idx_r  <= '0;
      req_r      <= 1'b0;
      op_r       <= OP_PROG;
      fladdr_r   <= '0;
    end else begin
      if (wr_fcr) begin
        if (!sfr_wdata[BIT_WPERMIT]) begin
          permit_r <= 1'b0;                                      // [RQ4] [RQ5]
        end
        mode_r    <= sfr_wdata[MODE_MSB:MODE_LSB];               // [RQ6]
        rpermit_r <= sfr_wdata[BIT_RPERMIT];
        if (sfr_wdata[BIT_MCHG]) begin
          mchg_r <= 1'b1;                                        // [RQ8]
        end
        if (sfr_wdata[BIT_WCYC]) begin
          wcyc_r <= 1'b1;                                        // [RQ10]
        end
        if (sfr_wdata[BIT_RCYC] && rpermit_r) begin
          rcyc_r <= 1'b1;                                        // [RQ12] [RQ13]
        end
      end
      if (wr_flash_buffer_control) begin
        soft_rst_r <= sfr_wdata[BIT_SOFT_RST];                   // [RQ16]
        if (sfr_wdata[BIT_BUF_CLR]) begin
          bclr_r <= 1'b1;                                        // [RQ15]
        end
      end
      if (wr_data && sfr_addr >= IDX_DATA0_LO + 4'h2) begin
        seen_r[3'(IDX_DATA3_HI - sfr_addr)] <= 1'b1;
      end
      case (st_r)
        ST_IDLE: begin
          if (mchg_r && mode_r == MODE_WEN) begin
            st_r   <= ST_UNLOCK;                                 // [RQ19]
            cnt_r  <= '0;
            seen_r <= '0;
          end else if (mchg_r) begin
            mchg_r <= 1'b0;                                      // [RQ9] [RQ7]
          end else if (wcyc_r && permit_r && mode_pg) begin
            st_r     <= ST_FLASH;
            req_r    <= 1'b1;
            op_r     <= (mode_r == MODE_ERASE) ? OP_ERASE : OP_PROG;
            fladdr_r <= addr_r;
          end else if (wcyc_r) begin
            wcyc_r <= 1'b0;                                      // [RQ10]
          end else if (rd_go) begin
            st_r     <= ST_FLASH;
            req_r    <= 1'b1;
            op_r     <= OP_READ;
            fladdr_r <= addr_r;
          end else if (rcyc_r) begin
            rcyc_r <= 1'b0;                                      // [RQ11]
          end else if (bclr_r) begin
            st_r      <= ST_CLEAR;
            clr_idx_r <= '0;
          end
        end
        ST_UNLOCK: begin
          cnt_r <= cnt_r + CW'(1);
          if (pat_ok) begin
            permit_r <= 1'b1;                                    // [RQ19]
            mchg_r   <= 1'b0;
            st_r     <= ST_IDLE;
          end else if (cnt_r == CNT_LAST) begin
            mchg_r <= 1'b0;                                      // [RQ19] [RQ9]
            st_r   <= ST_IDLE;
          end
        end
        ST_FLASH: begin
          if (fl_done) begin
            req_r <= 1'b0;
            if (op_r == OP_READ) begin
              rcyc_r <= 1'b0;                                    // [RQ12]
              st_r   <= ST_IDLE;
            end else if (op_r == OP_PROG) begin
              wcyc_r    <= 1'b0;
              st_r      <= ST_CLEAR;                             // [RQ21]
              clr_idx_r <= '0;
            end else begin
              wcyc_r <= 1'b0;                                    // [RQ10]
              st_r   <= ST_IDLE;
            end
          end
        end
        ST_CLEAR: begin
          clr_idx_r <= clr_idx_r + PAGE_AW'(1);
          if (clr_idx_r == PAGE_LAST) begin
            bclr_r <= 1'b0;                                      // [RQ15]
            st_r   <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign sfr_rdata   = rdata_r;
  assign fl_req      = req_r;
  assign fl_op       = op_r;
  assign fl_addr     = fladdr_r;
  assign fl_buf_data = buf_bus.rdata;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  wen_clear_a: assert property (wr_fcr && !sfr_wdata[BIT_WPERMIT]
    |=> !permit_r) else $error("write permit not cleared"); // [RQ4]
  wen_set_a: assert property ($rose(permit_r)
    |-> $past(st_r == ST_UNLOCK) && $past(pat_ok))
    else $error("write permit set outside unlock"); // [RQ5]
  unlock_win_a: assert property (st_r == ST_UNLOCK
    |-> cnt_r <= CNT_LAST) else $error("unlock window overrun"); // [RQ19]
  unlock_end_a: assert property (st_r == ST_UNLOCK && cnt_r == CNT_LAST
    |=> st_r == ST_IDLE && !mchg_r) else $error("unlock not ended"); // [RQ19]
  mode_done_a: assert property (st_r == ST_IDLE && mchg_r
    && mode_r != MODE_WEN |=> !mchg_r) else $error("mode bit stuck"); // [RQ9]
  rd_gate_a: assert property ($rose(rcyc_r) |-> $past(rpermit_r))
    else $error("read started without permit"); // [RQ13]
  rd_block_a: assert property ($rose(req_r) && op_r == OP_READ
    |-> $past(rpermit_r)) else $error("read without permit"); // [RQ11]
  wr_done_a: assert property (st_r == ST_FLASH && fl_done
    && op_r != OP_READ |=> !wcyc_r && !req_r)
    else $error("write bit not cleared"); // [RQ10]
  auto_clr_a: assert property (st_r == ST_FLASH && fl_done
    && op_r == OP_PROG |=> st_r == ST_CLEAR)
    else $error("buffer not auto cleared"); // [RQ21]
  addr_stop_a: assert property (wr_d0hi && page_end && !wr_alo
    && !wr_ahi |=> $stable(addr_r)) else $error("page crossed"); // [RQ20]
  rsv_zero_a: assert property (sfr_rd && sfr_addr == IDX_BUF_CTRL
    |=> (sfr_rdata & 8'hEE) == 8'h00) else $error("reserved bits set"); // [RQ17]
endmodule

// file: bench/fpmc_flash_model.sv
// Behavioural flash array on the far side of the control block.
// Assumes the controller holds fl_req until it sees fl_done.
`timescale 1ns/1ps
module fpmc_flash_model #(
  parameter int AW = 14,
  parameter int PW = 6
) (
  input  wire logic          clock,
  input  wire logic          arst_n,
  input  wire logic          fl_req,
  input  wire logic [1:0]    fl_op,
  input  wire logic [AW-1:0] fl_addr,
  output logic               fl_done,
  output logic      [15:0]   fl_rdata,
  output logic      [PW-1:0] fl_buf_idx,
  input  wire logic [15:0]   fl_buf_data
);
  logic [15:0]   page [2**PW];
  logic [1:0]    last_op;
  logic [AW-1:0] last_addr;
  int            cnt;
  int            n_req;

  // Walks the whole buffer for every request, then gives a one-cycle done
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt = 0;
      n_req = 0;
      fl_done <= 1'b0;
      fl_rdata <= 16'h5A5A;
      fl_buf_idx <= '0;
    end else begin
      fl_done <= 1'b0;
      fl_rdata <= ~fl_rdata; // Read word is only good with done
      if (fl_req && !fl_done) begin
        if (cnt == 0) begin
          n_req++;
          last_op <= fl_op;
          last_addr <= fl_addr;
        end
        if (cnt >= 2) page[cnt-2] <= fl_buf_data; // Buffer data lags index
        fl_buf_idx <= PW'(cnt);
        cnt++;
        if (cnt == 2**PW + 2) begin
          fl_done <= 1'b1;
          cnt = 0;
          fl_rdata <= {~fl_addr[7:0], fl_addr[7:0]};
        end
      end
    end
  end
endmodule

// file: bench/fpmc_top_tb_top.sv
// Self-checking bench for the flash program memory control block.
// Assumes the behavioural flash array model on the far side.
`timescale 1ns/1ps
module fpmc_top_tb_top;
  import fpmc_pkg::*;
  logic        clock;
  logic        arst_n;
  logic [3:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        fl_req;
  logic [1:0]  fl_op;
  logic [13:0] fl_addr;
  logic        fl_done;
  logic [15:0] fl_rdata;
  logic [5:0]  fl_buf_idx;
  logic [15:0] fl_buf_data;
  int          n_errors;
  int          checks_done;
  int          n0;

  fpmc_top #(.AHI_W(6), .PAGE_AW(6), .UNLOCK_CYC(20)) fpmc_top_i (
    .clock(clock), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .fl_req(fl_req), .fl_op(fl_op), .fl_addr(fl_addr), .fl_done(fl_done),
    .fl_rdata(fl_rdata), .fl_buf_idx(fl_buf_idx),
    .fl_buf_data(fl_buf_data));

  fpmc_flash_model #(.AW(14), .PW(6)) fpmc_flash_model_i (
    .clock(clock), .arst_n(arst_n), .fl_req(fl_req), .fl_op(fl_op),
    .fl_addr(fl_addr), .fl_done(fl_done), .fl_rdata(fl_rdata),
    .fl_buf_idx(fl_buf_idx), .fl_buf_data(fl_buf_data));

  // Free-running system clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Closing report, shared by the main sequence and stuck waits
  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One register write, strobe held for exactly one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask

  // One register read; data is registered at the strobe edge
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    rd(a);
    chk({8'h00, sfr_rdata}, {8'h00, exp});
  endtask

  // Polls a self-clearing bit under a bounded count
  task automatic wait_clr(input logic [3:0] a, input int b);
    for (int i = 0; i < 200; i++) begin
      rd(a);
      if (sfr_rdata[b] === 1'b0) return;
    end
    n_errors++;
    $display("unexpected at %0t: start bit never cleared", $time);
    report_and_stop();
  endtask

  task automatic t_reset();
    rchk(IDX_MODE_CTRL, CTRL_RESET);
    rchk(IDX_BUF_CTRL, CTRL_RESET);
    rchk(4'hC, 8'h00);
  endtask

  task automatic t_regs();
    wr(IDX_ADDR_LO, 8'hA5);
    rchk(IDX_ADDR_LO, 8'hA5);
    wr(IDX_ADDR_HI, 8'h2A);
    rchk(IDX_ADDR_HI, 8'h2A);
    for (int i = 0; i < 8; i++) wr(IDX_DATA0_LO + 4'(i), 8'(8'h13 * i + 1));
    for (int i = 0; i < 8; i++) rchk(IDX_DATA0_LO + 4'(i), 8'(8'h13 * i + 1));
    wr(IDX_BUF_CTRL, 8'hEE);
    rchk(IDX_BUF_CTRL, 8'h00);
    wr(IDX_BUF_CTRL, 8'h00);
  endtask

  task automatic t_modes();
    logic [2:0] codes [4];
    codes = '{MODE_WRITE, MODE_ERASE, MODE_READ, MODE_WEN};
    wr(IDX_MODE_CTRL, 8'h80);
    rchk(IDX_MODE_CTRL, 8'h00);
    // Only documented codes are ever written
    for (int i = 0; i < 4; i++) begin
      wr(IDX_MODE_CTRL, {1'b0, codes[i], 4'h0});
      rchk(IDX_MODE_CTRL, {1'b0, codes[i], 4'h0});
    end
    // Mode change in read mode completes without the unlock window
    wr(IDX_MODE_CTRL, 8'h38);
    wait_clr(IDX_MODE_CTRL, BIT_MCHG);
    chk({8'h00, sfr_rdata}, 16'h0030);
    wr(IDX_MODE_CTRL, 8'h04);
    wait_clr(IDX_MODE_CTRL, BIT_WCYC);
    chk(16'(fpmc_flash_model_i.n_req), 16'h0000);
  endtask

  task automatic t_unlock(input logic good);
    wr(IDX_MODE_CTRL, 8'h68);
    for (int k = 0; k < 6; k++)
      wr(4'(4 + k), UNLOCK_PAT[47-8*k -: 8] ^ {7'h00, !good && k == 5});
    wait_clr(IDX_MODE_CTRL, BIT_MCHG);
    chk({15'h0, sfr_rdata[7]}, {15'h0, good});
  endtask

  task automatic t_program();
    wr(IDX_ADDR_LO, 8'h3E);
    wr(IDX_ADDR_HI, 8'h01);
    wr(IDX_MODE_CTRL, 8'h80);
    wr(IDX_DATA0_LO, 8'h34);
    wr(IDX_DATA0_LO + 4'h1, 8'h12);
    rchk(IDX_ADDR_LO, 8'h3F);
    wr(IDX_DATA0_LO, 8'h78);
    wr(IDX_DATA0_LO + 4'h1, 8'h56);
    rchk(IDX_ADDR_LO, 8'h3F);
    wr(IDX_DATA0_LO, 8'hBC);
    wr(IDX_DATA0_LO + 4'h1, 8'h9A);
    wr(IDX_MODE_CTRL, 8'h84);
    wait_clr(IDX_MODE_CTRL, BIT_WCYC);
    chk(16'(fpmc_flash_model_i.last_op), 16'(OP_PROG));
    chk(16'(fpmc_flash_model_i.last_addr), 16'h013F);
    chk(fpmc_flash_model_i.page[62], 16'h1234);
    chk(fpmc_flash_model_i.page[63], 16'h9ABC);
    wr(IDX_MODE_CTRL, 8'h84);
    wait_clr(IDX_MODE_CTRL, BIT_WCYC);
    chk(fpmc_flash_model_i.page[62], 16'h0000);
  endtask

  task automatic t_erase();
    wr(IDX_MODE_CTRL, 8'h94);
    wait_clr(IDX_MODE_CTRL, BIT_WCYC);
    chk(16'(fpmc_flash_model_i.last_op), 16'(OP_ERASE));
  endtask

  task automatic t_read();
    wr(IDX_ADDR_LO, 8'h5C);
    n0 = fpmc_flash_model_i.n_req;
    wr(IDX_MODE_CTRL, 8'hB1);
    rchk(IDX_MODE_CTRL, 8'hB0);
    chk(16'(fpmc_flash_model_i.n_req), 16'(n0));
    // Permit and start go in separate writes
    wr(IDX_MODE_CTRL, 8'hB2);
    wr(IDX_MODE_CTRL, 8'hB3);
    wait_clr(IDX_MODE_CTRL, BIT_RCYC);
    chk(16'(fpmc_flash_model_i.last_op), 16'(OP_READ));
    chk(16'(fpmc_flash_model_i.last_addr), 16'h015C);
    rchk(IDX_DATA0_LO, 8'h5C);
    rchk(IDX_DATA0_LO + 4'h1, 8'hA3);
  endtask

  task automatic t_clear();
    wr(IDX_MODE_CTRL, 8'h80);
    wr(IDX_ADDR_LO, 8'h05);
    wr(IDX_DATA0_LO, 8'h77);
    wr(IDX_DATA0_LO + 4'h1, 8'h66);
    wr(IDX_BUF_CTRL, 8'h01);
    wait_clr(IDX_BUF_CTRL, BIT_BUF_CLR);
    wr(IDX_MODE_CTRL, 8'h84);
    wait_clr(IDX_MODE_CTRL, BIT_WCYC);
    chk(fpmc_flash_model_i.page[5], 16'h0000);
  endtask

  task automatic t_disable();
    wr(IDX_MODE_CTRL, 8'h00);
    rchk(IDX_MODE_CTRL, 8'h00);
    n0 = fpmc_flash_model_i.n_req;
    wr(IDX_MODE_CTRL, 8'h04);
    wait_clr(IDX_MODE_CTRL, BIT_WCYC);
    chk(16'(fpmc_flash_model_i.n_req), 16'(n0));
  endtask

  // Reset, then the scenarios in order
  initial begin
    arst_n = 1'b0;
    sfr_addr = 4'h0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    n_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_modes();
    t_unlock(1'b0);
    t_unlock(1'b1);
    t_program();
    t_erase();
    t_read();
    t_clear();
    t_disable();
    report_and_stop();
  end
endmodule
